// ### hw/fhb_host_if.sv
// Programmed-I/O bridge between a multiplexed asynchronous host bus and a
// serial floppy controller link. Assumes all pins are asynchronous to core_clk
// and that the bus and link wires are resolved outside from the enables.

`timescale 1ns/10ps

module fhb_host_if
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire fhb_pkg::fhb_host_in_t hostIn,
  input  wire fhb_pkg::fhb_ctl_in_t  ctlIn,
  input  wire fhb_pkg::fhb_strap_t   strapIn,
  output logic [15:0]               busDalOut,
  output logic                      busDalOe_n,
  output logic                      busReply,
  output logic                      busIrq,
  output logic                      rxLineOut,
  output logic                      rxLineOe_n,
  output logic                      ctlRun,
  output logic                      driveInit
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic                 rstMeta_n;
  logic                 rstSync_n;
  fhb_pkg::fhb_state_t  r;
  fhb_pkg::fhb_state_t  n;
  fhb_pkg::fhb_host_in_t host;
  fhb_pkg::fhb_ctl_in_t  ctl;
  fhb_pkg::fhb_strap_t   strap;
  logic                 busy;
  logic                 syncRise;
  logic                 shiftRise;
  logic                 doneRise;
  logic                 addressMatch;
  logic                 ackCycle;
  logic [7:0]           dalLow;

  // Reset is asserted at once but released only after two clean edges.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ****************************************************************
  // Synchronised views and derived events
  // ****************************************************************
  // Only the second stage is looked at; the first stage feeds nothing else.
  assign host         = r.sync2.host;
  assign ctl          = r.sync2.ctl;
  assign strap        = r.sync2.strap;
  assign dalLow       = host.dal[7:0];
  assign busy         = !ctl.xferReq && !ctl.done;  // RULE13
  assign syncRise     = host.sync && !r.prevSync;
  assign shiftRise    = ctl.shift && !r.prevShift;
  assign doneRise     = ctl.done && !r.prevDone;
  assign addressMatch = host.dal[fhb_pkg::ADDR_HI:fhb_pkg::ADDR_LO] == strap.addr;  // RULE1
  assign ackCycle     = host.iak && host.din && r.irqPend;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // One pass builds the whole next state; ordering below gives set over clear.
  always_comb
  begin
    n           = r;
    n.sync1     = {hostIn, ctlIn, strapIn};
    n.sync2     = r.sync1;
    n.prevSync  = host.sync;
    n.prevShift = ctl.shift;
    n.prevDone  = ctl.done;

    // The controller taking the run request drops it again.
    if (busy)
    begin
      n.run = 1'b0;
    end

    // Serial engine; the frame counter rests while the link is idle.
    if (!busy)
    begin
      n.bitCnt   = 4'h0;
      n.parAcc   = 1'b0;
      n.lineOe_n = 1'b1;
    end
    else if (!ctl.dir)  // RULE20
    begin
      n.lineOe_n = 1'b0;
      if (shiftRise && r.bitCnt < fhb_pkg::DATA_BITS)
      begin
        n.serOut   = r.shiftBuf[7];  // RULE5
        n.shiftBuf = {r.shiftBuf[6:0], 1'b0};  // RULE3
        n.parAcc   = r.parAcc ^ r.shiftBuf[7];
        n.bitCnt   = r.bitCnt + 4'h1;
      end
      else if (shiftRise && r.bitCnt == fhb_pkg::DATA_BITS)
      begin
        n.serOut = r.parAcc ^ fhb_pkg::PARITY_ODD;  // RULE18
        n.bitCnt = fhb_pkg::FRAME_END;
      end
    end
    else
    begin
      n.lineOe_n = 1'b1;
      if (shiftRise && r.bitCnt < fhb_pkg::DATA_BITS)
      begin
        n.shiftBuf = {r.shiftBuf[6:0], ctl.line};  // RULE6
        n.parAcc   = r.parAcc ^ ctl.line;
        n.bitCnt   = r.bitCnt + 4'h1;
      end
      else if (shiftRise && r.bitCnt == fhb_pkg::DATA_BITS)
      begin
        // A bad parity bit is kept sticky until the next go command.
        if ((r.parAcc ^ fhb_pkg::PARITY_ODD) != ctl.line)
        begin
          n.parityErr = 1'b1;
        end
        n.bitCnt = fhb_pkg::FRAME_END;
      end
    end

    // Host bus slave.
    case (r.bus)
      fhb_pkg::BUS_IDLE:
      begin
        n.reply     = 1'b0;
        n.dalOe_n   = 1'b1;
        n.initPulse = 1'b0;
        if (ackCycle)
        begin
          n.dalOut  = {7'h00, strap.vector, 2'h0};  // RULE15
          n.dalOe_n = 1'b0;
          n.irqPend = 1'b0;
          n.bus     = fhb_pkg::BUS_REPLY;
        end
        else if (syncRise && !host.iak && addressMatch)  // RULE1
        begin
          n.regSel = host.dal[fhb_pkg::REG_SEL_BIT];  // RULE2
          n.bus    = fhb_pkg::BUS_MATCH;
        end
      end
      fhb_pkg::BUS_MATCH:
      begin
        if (!host.sync)
        begin
          n.bus = fhb_pkg::BUS_IDLE;
        end
        else if (host.dout && r.regSel)
        begin
          // Buffer loads are refused while a serial frame is moving.
          if (!busy)
          begin
            n.shiftBuf = dalLow;  // RULE4
            n.bitCnt   = 4'h0;
            n.parAcc   = 1'b0;
            n.run      = ctl.xferReq;  // RULE19
          end
          n.bus = fhb_pkg::BUS_REPLY;
        end
        else if (host.dout)
        begin
          n.irqAllow = host.dal[fhb_pkg::CSR_IE];  // RULE12
          if (!host.dal[fhb_pkg::CSR_IE])
          begin
            n.irqPend = 1'b0;
          end
          if (host.dal[fhb_pkg::CSR_INIT])
          begin
            n.initPulse = 1'b1;  // RULE16
            n.run       = 1'b0;
          end
          // Only a go with the controller idle starts a command frame.
          if (host.dal[fhb_pkg::CSR_GO] && ctl.done && !host.dal[fhb_pkg::CSR_INIT])  // RULE11
          begin
            n.shiftBuf  = dalLow;  // RULE10
            n.bitCnt    = 4'h0;
            n.parAcc    = 1'b0;
            n.parityErr = 1'b0;
            n.run       = 1'b1;  // RULE19
          end
          n.bus = fhb_pkg::BUS_REPLY;
        end
        else if (host.din)
        begin
          n.dalOe_n = 1'b0;
          if (r.regSel)
          begin
            n.dalOut = {8'h00, r.shiftBuf};  // RULE7
            if (ctl.xferReq)
            begin
              n.run = 1'b1;  // RULE19
            end
          end
          else
          begin
            // Ten implemented positions; the rest and write-only bits read zero.
            n.dalOut                   = fhb_pkg::DAL_RESET;  // RULE8 RULE21
            n.dalOut[fhb_pkg::CSR_ERR]  = ctl.error || r.parityErr;  // RULE9
            n.dalOut[fhb_pkg::CSR_XFER] = ctl.xferReq;
            n.dalOut[fhb_pkg::CSR_IE]   = r.irqAllow;
            n.dalOut[fhb_pkg::CSR_DONE] = ctl.done;
          end
          n.bus = fhb_pkg::BUS_REPLY;
        end
      end
      fhb_pkg::BUS_REPLY:
      begin
        // Reply follows one edge after the data was latched or put out.
        n.reply = 1'b1;  // RULE22
        if (!host.din && !host.dout)
        begin
          n.reply     = 1'b0;
          n.dalOe_n   = 1'b1;
          n.initPulse = 1'b0;  // RULE17
          n.bus       = fhb_pkg::BUS_IDLE;
        end
      end
      default:
      begin
        n.bus = fhb_pkg::BUS_IDLE;
      end
    endcase

    // Done rising with interrupts allowed wins over any clear in this cycle.
    if (doneRise && r.irqAllow)
    begin
      n.irqPend = 1'b1;  // RULE14
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Every field resets to a constant; straps are only seen after release.
  always_ff @(posedge core_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      r          <= '0;
      r.bus      <= fhb_pkg::BUS_IDLE;
      r.shiftBuf <= fhb_pkg::BUF_RESET;
      r.irqAllow <= fhb_pkg::IE_RESET;
      r.dalOut   <= fhb_pkg::DAL_RESET;
      r.dalOe_n  <= 1'b1;
      r.lineOe_n <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  // Outputs come straight from the state register.
  assign busDalOut  = r.dalOut;
  assign busDalOe_n = r.dalOe_n;
  assign busReply   = r.reply;
  assign busIrq     = r.irqPend;
  assign rxLineOut  = r.serOut;
  assign rxLineOe_n = r.lineOe_n;
  assign ctlRun     = r.run;
  assign driveInit  = r.initPulse;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_addr_match_enter: assert property (  // RULE1
    @(posedge core_clk) disable iff (!rstSync_n)
    (r.bus == fhb_pkg::BUS_IDLE && syncRise && !host.iak && addressMatch)
      |=> (r.bus == fhb_pkg::BUS_MATCH && r.regSel == $past(host.dal[1])))
    else $error("Matching address did not open a cycle.");

  a_db_write_load: assert property (  // RULE4
    @(posedge core_clk) disable iff (!rstSync_n)
    (r.bus == fhb_pkg::BUS_MATCH && host.sync && host.dout && r.regSel && !busy)
      |=> (r.shiftBuf == $past(dalLow)))
    else $error("Buffer write did not load the data byte.");

  a_csr_read_bits: assert property (  // RULE9
    @(posedge core_clk) disable iff (!rstSync_n)
    (r.bus == fhb_pkg::BUS_MATCH && host.sync && !host.dout && host.din && !r.regSel)
      |=> (!busDalOe_n && busDalOut[7] == $past(ctl.xferReq)
           && busDalOut[6] == $past(r.irqAllow) && busDalOut[5] == $past(ctl.done)
           && busDalOut[4:0] == 5'h00 && busDalOut[14:8] == 7'h00))
    else $error("Status word read shows wrong bits.");

  a_go_low_nosend: assert property (  // RULE11
    @(posedge core_clk) disable iff (!rstSync_n)
    (r.bus == fhb_pkg::BUS_MATCH && host.sync && host.dout && !r.regSel
     && !host.dal[0] && !ctlRun)
      |=> !ctlRun)
    else $error("Status write with go clear started a transfer.");

  a_irq_on_done: assert property (  // RULE14
    @(posedge core_clk) disable iff (!rstSync_n)
    (doneRise && r.irqAllow) |=> busIrq)
    else $error("Done with interrupts allowed raised no request.");

  a_vector_drive: assert property (  // RULE15
    @(posedge core_clk) disable iff (!rstSync_n)
    (r.bus == fhb_pkg::BUS_IDLE && ackCycle)
      |=> (!busDalOe_n && busDalOut[8:2] == $past(strap.vector)) ##1 busReply)
    else $error("Acknowledge did not return the vector.");

  a_init_pulse_on: assert property (  // RULE16
    @(posedge core_clk) disable iff (!rstSync_n)
    (r.bus == fhb_pkg::BUS_MATCH && host.sync && host.dout && !r.regSel && host.dal[14])
      |=> driveInit)
    else $error("Status write with init set gave no pulse.");

  // The pulse must fall with the reply, so a stuck pulse is caught here.
  a_init_pulse_end: assert property (  // RULE17
    @(posedge core_clk) disable iff (!rstSync_n)
    (r.bus == fhb_pkg::BUS_REPLY && !host.din && !host.dout)
      |=> (!driveInit && r.bus == fhb_pkg::BUS_IDLE))
    else $error("Init pulse outlived the write cycle.");

  a_go_starts_run: assert property (  // RULE10
    @(posedge core_clk) disable iff (!rstSync_n)
    (r.bus == fhb_pkg::BUS_MATCH && host.sync && host.dout && !r.regSel
     && host.dal[0] && !host.dal[14] && ctl.done)
      |=> ctlRun)
    else $error("Go write with the controller idle raised no run.");

  a_parity_ninth: assert property (  // RULE18
    @(posedge core_clk) disable iff (!rstSync_n)
    (busy && shiftRise && !ctl.dir && r.bitCnt == fhb_pkg::DATA_BITS)
      |=> (rxLineOut == ($past(r.parAcc) ^ fhb_pkg::PARITY_ODD)
           && r.bitCnt == fhb_pkg::FRAME_END))
    else $error("Parity bit not sent after eight data bits.");

  a_reply_after_data: assert property (  // RULE22
    @(posedge core_clk) disable iff (!rstSync_n)
    $rose(busReply) |-> ($past(r.bus) == fhb_pkg::BUS_REPLY && $past(host.din || host.dout)))
    else $error("Reply came before data was handled.");

endmodule

// ### hw/fhb_pkg.sv
// Constants and carrier types for the floppy host bus interface.
// Assumes a single core clock; every host and controller pin is asynchronous to it.
//
// Summary of operation
// RULE1 - Decode address bits 2..12 at sync start.
// RULE2 - Address bit 1 selects status or buffer.
// RULE3 - Buffer is 8-bit loadable, readable shift register.
// RULE4 - Buffer write loads data bits 0..7.
// RULE5 - Send shifts MSB first plus parity bit.
// RULE6 - Receive shifts serial bits into buffer.
// RULE7 - Buffer read drives bits 0..7 onto bus.
// RULE8 - Status word implements only ten bit positions.
// RULE9 - Status read: error 15, request 7, enable 6, done 5.
// RULE10 - Go write loads command byte, then sends it.
// RULE11 - Go clear write sends no command.
// RULE12 - Every status write updates interrupt enable bit 6.
// RULE13 - Request, done, error come from controller handshakes.
// RULE14 - Enable and done rising raise interrupt request.
// RULE15 - Acknowledge with data-in gets the strap vector.
// RULE16 - Status write with bit 14 pulses drive init.
// RULE17 - Init pulse lasts only for that write cycle.
// RULE18 - Count eight sent bits, then append parity.
// RULE19 - Run with done is command, else data.
// RULE20 - Controller drives direction high for controller-to-interface.
// RULE21 - Unused and write-only status bits read zero.
// RULE22 - Reply only after data latched or driven.

package fhb_pkg;

  // ****************************************************************
  // Register fields and address decode
  // ****************************************************************
  localparam int ADDR_LO     = 2;
  localparam int ADDR_HI     = 12;
  localparam int REG_SEL_BIT = 1;
  localparam int CSR_GO      = 0;
  localparam int CSR_FUNC_LO = 1;
  localparam int CSR_FUNC_HI = 3;
  localparam int CSR_DONE    = 5;
  localparam int CSR_IE      = 6;
  localparam int CSR_XFER    = 7;
  localparam int CSR_INIT    = 14;
  localparam int CSR_ERR     = 15;
  localparam int VEC_LO      = 2;
  localparam int VEC_HI      = 8;

  // ****************************************************************
  // Reset values and serial framing
  // ****************************************************************
  localparam logic [7:0]  BUF_RESET  = 8'h00;
  localparam logic        IE_RESET   = 1'b0;
  localparam logic [15:0] DAL_RESET  = 16'h0000;
  localparam logic [3:0]  DATA_BITS  = 4'h8;
  localparam logic [3:0]  FRAME_END  = 4'h9;
  localparam logic        PARITY_ODD = 1'b1;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [15:0] dal;
    logic        sync;
    logic        din;
    logic        dout;
    logic        iak;
  } fhb_host_in_t;

  typedef struct packed {
    logic line;
    logic shift;
    logic xferReq;
    logic done;
    logic error;
    logic dir;
  } fhb_ctl_in_t;

  typedef struct packed {
    logic [ADDR_HI:ADDR_LO] addr;
    logic [VEC_HI:VEC_LO]   vector;
  } fhb_strap_t;

  typedef struct packed {
    fhb_host_in_t host;
    fhb_ctl_in_t  ctl;
    fhb_strap_t   strap;
  } fhb_pins_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_MATCH,
    BUS_REPLY
  } fhb_bus_st_t;

  typedef struct packed {
    fhb_pins_t   sync1;
    fhb_pins_t   sync2;
    logic        prevSync;
    logic        prevShift;
    logic        prevDone;
    fhb_bus_st_t bus;
    logic        regSel;
    logic [7:0]  shiftBuf;
    logic [3:0]  bitCnt;
    logic        parAcc;
    logic        parityErr;
    logic        serOut;
    logic        lineOe_n;
    logic        run;
    logic        irqAllow;
    logic        irqPend;
    logic        initPulse;
    logic [15:0] dalOut;
    logic        dalOe_n;
    logic        reply;
  } fhb_state_t;

endpackage

// ### testbench/fhb_ctl_model.sv
// Behavioural floppy controller on the serial side of the host interface.
// Assumes it shares core_clk; strobes are slow so that they survive the synchronisers.

`timescale 1ns/10ps

module fhb_ctl_model
(
  input  wire logic            core_clk,
  input  wire logic            ctlRun,
  input  wire logic            rxLineOut,
  input  wire logic            rxLineOe_n,
  output fhb_pkg::fhb_ctl_in_t ctlIn
);
  logic shiftLvl = 1'b0;
  logic reqLvl   = 1'b0;
  logic doneLvl  = 1'b1;
  logic errLvl   = 1'b0;
  logic dirLvl   = 1'b0;
  logic drvOn    = 1'b0;
  logic drvBit   = 1'b0;
  logic lastLine = 1'b0;
  logic lineLvl;

  // A released line shows the inverse of its last level, so stale bits never pass.
  assign lineLvl = !rxLineOe_n ? rxLineOut : (drvOn ? drvBit : ~lastLine);
  assign ctlIn   = '{lineLvl, shiftLvl, reqLvl, doneLvl, errLvl, dirLvl};

  // Remember the line level for the released case.
  always @(posedge core_clk)
  begin
    lastLine <= lineLvl;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Busy is request and done both low; direction high means we send.
  task automatic set_lines(input logic req, input logic done, input logic err, input logic dir);
    reqLvl  = req;
    doneLvl = done;
    errLvl  = err;
    dirLvl  = dir;
    tick(6);
  endtask

  // One shift strobe; the interface bit is sampled late in the high phase.
  task automatic pulse(output logic seen);
    shiftLvl = 1'b1;
    tick(5);
    seen     = rxLineOe_n ? 1'bx : rxLineOut;
    shiftLvl = 1'b0;
    tick(5);
  endtask

  // Run with done high is a command, with request high a data byte; take nine bits.
  task automatic take_frame(output logic [8:0] bits);
    logic b;
    int   i;
    bits = '0;
    for (i = 0; i < 40 && ctlRun !== 1'b1; i++)
      tick(1);
    set_lines(1'b0, 1'b0, 1'b0, 1'b0);
    for (i = 0; i < 9; i++)
    begin
      pulse(b);
      bits = {bits[7:0], b};
    end
    // Ask for the next element; leaving busy lets the frame counter rest.
    set_lines(1'b1, 1'b0, 1'b0, 1'b0);
  endtask

  // Send a byte MSB first with odd parity, optionally corrupted, then offer it.
  task automatic give_byte(input logic [7:0] data, input logic badPar);
    logic [8:0] frame;
    logic       b;
    int         i;
    frame = {data, ~^data ^ badPar};
    set_lines(1'b0, 1'b0, 1'b0, 1'b1);
    drvOn = 1'b1;
    for (i = 8; i >= 0; i--)
    begin
      drvBit = frame[i];
      pulse(b);
    end
    drvOn = 1'b0;
    set_lines(1'b1, 1'b0, 1'b0, 1'b1);
  endtask
endmodule

// ### testbench/tb_floppy_host_bus_interface.sv
// Self-checking bench for the floppy host bus interface.
// Assumes fhb_ctl_model on the controller side and static strap settings.

`timescale 1ns/10ps

module tb_floppy_host_bus_interface;
  localparam logic [10:0] STRAP_ADDR = 11'h3e7;
  localparam logic [6:0]  STRAP_VEC  = 7'h2d;
  localparam logic [15:0] CSR_ADDR   = {3'h0, STRAP_ADDR, 2'h0};
  localparam logic [15:0] BUF_ADDR   = {3'h0, STRAP_ADDR, 2'h2};

  logic                  core_clk    = 1'b0;
  logic                  rst_n       = 1'b0;
  fhb_pkg::fhb_host_in_t hostIn      = '0;
  fhb_pkg::fhb_strap_t   strapIn     = '{STRAP_ADDR, STRAP_VEC};
  fhb_pkg::fhb_ctl_in_t  ctlIn;
  logic [15:0]           busDalOut;
  logic                  busDalOe_n;
  logic                  busReply;
  logic                  busIrq;
  logic                  rxLineOut;
  logic                  rxLineOe_n;
  logic                  ctlRun;
  logic                  driveInit;
  logic                  ok;
  logic                  initAtReply;
  logic [15:0]           got;
  int                    miscompares = 0;
  int                    checks_done = 0;

  initial forever #50 core_clk = ~core_clk;

  fhb_host_if u_fhb_host_if
  (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .hostIn     (hostIn),
    .ctlIn      (ctlIn),
    .strapIn    (strapIn),
    .busDalOut  (busDalOut),
    .busDalOe_n (busDalOe_n),
    .busReply   (busReply),
    .busIrq     (busIrq),
    .rxLineOut  (rxLineOut),
    .rxLineOe_n (rxLineOe_n),
    .ctlRun     (ctlRun),
    .driveInit  (driveInit)
  );

  fhb_ctl_model u_fhb_ctl_model
  (
    .core_clk   (core_clk),
    .ctlRun     (ctlRun),
    .rxLineOut  (rxLineOut),
    .rxLineOe_n (rxLineOe_n),
    .ctlIn      (ctlIn)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One host cycle: kind 0 read, 1 write, 2 interrupt acknowledge.
  task automatic host(input int kind, input logic [15:0] addr, input logic [15:0] wdata);
    int i;
    hostIn.dal  = addr;
    hostIn.iak  = (kind == 2);
    hostIn.sync = (kind != 2);
    tick(4);
    hostIn.dal  = (kind == 1) ? wdata : ~addr;
    hostIn.dout = (kind == 1);
    hostIn.din  = (kind != 1);
    ok = 1'b0;
    for (i = 0; i < 20 && !ok; i++)
    begin
      tick(1);
      ok = (busReply === 1'b1);
    end
    got         = busDalOe_n ? 16'hxxxx : busDalOut;
    initAtReply = driveInit;
    hostIn.dout = 1'b0;
    hostIn.din  = 1'b0;
    for (i = 0; i < 20 && busReply !== 1'b0; i++)
      tick(1);
    hostIn = '0;
    tick(4);
  endtask

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    host(1, addr, data);
    chk("write reply", 16'h0001, {15'h0, ok});
  endtask

  task automatic rd(input string what, input logic [15:0] addr, input logic [15:0] exp);
    host(0, addr, 16'h0000);
    chk(what, exp, got);
  endtask

  // Nine bits on the wire: the byte MSB first, then odd parity.
  task automatic frame_chk(input string what, input logic [7:0] b);
    logic [8:0] frame;
    chk("run request", 16'h0001, {15'h0, ctlRun});
    u_fhb_ctl_model.take_frame(frame);
    chk(what, {7'h0, b, ~^b}, {7'h0, frame});
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // A hang costs far more than the roughly 800 cycles the tests need.
  initial
  begin
    tick(20000);
    miscompares++;
    stop_test;
  end

  // Main sequence.
  initial
  begin
    tick(5);
    rst_n = 1'b1;
    tick(6);
    rd("reset status", CSR_ADDR, 16'h0020);
    chk("reset pins", 16'h0000, {12'h0, busIrq, driveInit, ctlRun, rxLineOut});
    host(0, {3'h0, ~STRAP_ADDR, 2'h0}, 16'h0000);
    chk("foreign reply", 16'h0000, {15'h0, ok});
    rd("reset buffer", BUF_ADDR, 16'h0000);
    $display("test reset done");
    wr(CSR_ADDR, 16'h0040);
    tick(10);
    chk("run without go", 16'h0000, {15'h0, ctlRun});
    rd("enable status", CSR_ADDR, 16'h0060);
    $display("test enable done");
    wr(CSR_ADDR, 16'h0047);
    frame_chk("command frame", 8'h47);
    u_fhb_ctl_model.set_lines(1'b0, 1'b1, 1'b0, 1'b0);
    chk("irq on done", 16'h0001, {15'h0, busIrq});
    host(2, 16'h0000, 16'h0000);
    chk("vector", {7'h0, STRAP_VEC, 2'h0}, got);
    chk("irq after ack", 16'h0000, {15'h0, busIrq});
    $display("test command done");
    u_fhb_ctl_model.set_lines(1'b1, 1'b0, 1'b0, 1'b0);
    rd("request status", CSR_ADDR, 16'h00c0);
    wr(BUF_ADDR, 16'h12a5);
    frame_chk("data frame", 8'ha5);
    u_fhb_ctl_model.give_byte(8'h3c, 1'b0);
    rd("received byte", BUF_ADDR, 16'h003c);
    chk("run on read", 16'h0001, {15'h0, ctlRun});
    u_fhb_ctl_model.give_byte(8'hc3, 1'b1);
    rd("parity error", CSR_ADDR, 16'h80c0);
    $display("test data done");
    u_fhb_ctl_model.set_lines(1'b0, 1'b1, 1'b0, 1'b0);
    wr(CSR_ADDR, 16'h4000);
    chk("init in cycle", 16'h0001, {15'h0, initAtReply});
    chk("init after cycle", 16'h0000, {15'h0, driveInit});
    chk("irq disabled", 16'h0000, {15'h0, busIrq});
    wr(CSR_ADDR, 16'h0001);
    frame_chk("plain go frame", 8'h01);
    u_fhb_ctl_model.set_lines(1'b0, 1'b1, 1'b0, 1'b0);
    rd("error cleared", CSR_ADDR, 16'h0020);
    chk("no irq masked", 16'h0000, {15'h0, busIrq});
    $display("test init done");
    stop_test;
  end
endmodule
